// File: rtl/patch_loader_defines.svh
// Offsets, command codes, result codes, reset values and timing counts
`ifndef PATCH_LOADER_DEFINES_SVH
`define PATCH_LOADER_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define OFF_CMD 8'h00
`define OFF_PARAM0 8'h04
`define OFF_PARAM1 8'h08
`define OFF_PARAM2 8'h0C
`define OFF_STATE 8'h10
`define OFF_RAM 8'h14
`define OFF_SLOT0 8'h20

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CMD_DOORBELL_BIT 15
`define STATE_BUSY_BIT 0
`define STATE_USED_BIT 1

// ----------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------
`define CMD_LOAD 16'h8700
`define CMD_STATUS 16'h8701
`define CMD_APPLY 16'h8702
`define CMD_RESERVE 16'h8706

// ----------------------------------------------------------------------
// Result codes, one fixed value each
// ----------------------------------------------------------------------
`define RES_ENOERR 16'h0000
`define RES_ENOENT 16'h0001
`define RES_EIO 16'h0005
`define RES_EBADF 16'h0009
`define RES_EBUSY 16'h0010
`define RES_ENODEV 16'h0013
`define RES_EINVAL 16'h0016
`define RES_ERANGE 16'h0022
`define RES_ENOSYS 16'h0026

// ----------------------------------------------------------------------
// Reset values and defaults
// ----------------------------------------------------------------------
`define CMD_RESET 16'h0000
`define RAM_BASE_DEF 16'h4000
`define RAM_BYTES_DEF 16'h1000
`define ROM_FW_ID_DEF 32'h00010001
`define SLOT_COUNT 8

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 20
`define APPLY_TIME_NS 100
`define APPLY_CYCLES ((`APPLY_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: rtl/patch_loader_pkg.sv
// Types shared by the patch loader design
package patch_loader_pkg;
  typedef logic [15:0] result_type;

  typedef enum logic [1:0] {
    OP_IDLE = 2'b00,
    OP_LOADING = 2'b01,
    OP_APPLYING = 2'b10
  } op_state_type;

  typedef struct packed {
    logic valid;
    logic [15:0] index;
  } nvm_req_type;

  typedef struct packed {
    logic done;
    logic found;
    logic ok;
    logic [15:0] patch_id;
  } nvm_rsp_type;
endpackage : patch_loader_pkg

// File: rtl/patch_slot_mem.sv
// Applied patch identifier slots with registered read port
`timescale 1ns/10ps
module patch_slot_mem #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 16
) (
  input wire logic pclk,
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  // No reset on the array; the slot count tells software what is valid
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : patch_slot_mem

// File: rtl/patch_op_timer.sv
// Down counter that times a background apply
`timescale 1ns/10ps
module patch_op_timer #(
  parameter int WIDTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [WIDTH-1:0] cycles,
  output logic expired
);
  logic [WIDTH-1:0] count;

  assign expired = (count == WIDTH'(1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else if (start) begin
      count <= cycles;
    end else if (count != '0) begin
      count <= count - WIDTH'(1);
    end
  end
endmodule : patch_op_timer

// File: rtl/patch_loader_command_handler.sv
// Patch loader command handler with APB register access
`timescale 1ns/10ps
`include "patch_loader_defines.svh"
module patch_loader_command_handler #(
  parameter logic [15:0] RAM_BASE = `RAM_BASE_DEF,
  parameter logic [15:0] RAM_BYTES = `RAM_BYTES_DEF,
  // Firmware version value is arbitrary
  parameter logic [31:0] ROM_FW_ID = `ROM_FW_ID_DEF,
  parameter int SLOTS = `SLOT_COUNT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic nvm_present,
  output patch_loader_pkg::nvm_req_type nvm_req,
  input wire patch_loader_pkg::nvm_rsp_type nvm_rsp
);
  import patch_loader_pkg::*;

  localparam int SW = $clog2(SLOTS);
  localparam logic [7:0] SLOT_END = 8'(`OFF_SLOT0 + 4 * SLOTS);
  localparam logic [7:0] APPLY_N = 8'(`APPLY_CYCLES);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [15:0] cmd_reg;
  logic [15:0] param0;
  logic [15:0] param1;
  logic [31:0] param2;
  op_state_type state;
  result_type op_status;
  logic region_used;
  logic [15:0] reserved_total;
  logic [15:0] reserve_start;
  logic [15:0] apply_id;
  logic [SW-1:0] slot_ptr;
  logic [SW:0] slot_count;
  logic [31:0] prdata_q;
  logic [15:0] slot_rdata;
  logic timer_expired;

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  wire access = psel && penable;
  wire wr = access && pwrite;
  wire hit_cmd = paddr == `OFF_CMD;
  wire hit_p0 = paddr == `OFF_PARAM0;
  wire hit_p1 = paddr == `OFF_PARAM1;
  wire hit_p2 = paddr == `OFF_PARAM2;
  wire hit_state = paddr == `OFF_STATE;
  wire hit_ram = paddr == `OFF_RAM;
  wire hit_slot = paddr >= `OFF_SLOT0 && paddr < SLOT_END && paddr[1:0] == 2'b00;
  wire hit_any = hit_cmd || hit_p0 || hit_p1 || hit_p2 || hit_state || hit_ram || hit_slot;
  wire [7:0] slot_off = paddr - `OFF_SLOT0;
  wire [SW-1:0] slot_raddr = slot_off[SW+1:2];

  // Host may only set the doorbell; a write while it is up is dropped
  wire doorbell = cmd_reg[`CMD_DOORBELL_BIT];
  wire wr_cmd = wr && hit_cmd && !doorbell;

  assign pready = 1'b1;
  assign pslverr = access && !hit_any;
  assign prdata = hit_slot ? {16'h0000, slot_rdata} : prdata_q;

  // ----------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------
  wire op_busy = state != OP_IDLE;
  wire is_load = doorbell && cmd_reg == `CMD_LOAD;
  wire is_status = doorbell && cmd_reg == `CMD_STATUS;
  wire is_apply = doorbell && cmd_reg == `CMD_APPLY;
  wire is_reserve = doorbell && cmd_reg == `CMD_RESERVE;
  wire [16:0] ram_end = {1'b0, RAM_BASE} + {1'b0, RAM_BYTES};
  wire addr_bad = param0 < RAM_BASE || {1'b0, param0} >= ram_end;
  wire fw_bad = param2 != ROM_FW_ID;
  wire [15:0] free_bytes = RAM_BYTES - reserved_total;
  wire no_room = param1 > free_bytes;

  // Load, apply and status are checked busy first; reserve has no busy check and is accepted while an operation runs
  wire result_type load_res = op_busy ? `RES_EBUSY :
    !nvm_present ? `RES_ENODEV :
    region_used ? `RES_ERANGE : `RES_ENOERR;
  wire result_type apply_res = op_busy ? `RES_EBUSY :
    addr_bad ? `RES_EINVAL : fw_bad ? `RES_EBADF : `RES_ENOERR;
  wire result_type rsv_res = no_room ? `RES_EBUSY : `RES_ENOERR;
  wire result_type stat_res = op_busy ? `RES_EBUSY : op_status;
  wire result_type cmd_result = is_load ? load_res :
    is_status ? stat_res :
    is_apply ? apply_res :
    is_reserve ? rsv_res : `RES_ENOSYS;

  wire start_load = is_load && load_res == `RES_ENOERR;
  wire start_apply = is_apply && apply_res == `RES_ENOERR;
  wire reserve_ok = is_reserve && !no_room;
  wire load_done = state == OP_LOADING && nvm_rsp.done;
  wire load_ok = load_done && nvm_rsp.found && nvm_rsp.ok;
  wire start_timer = start_apply || load_ok;
  wire slot_we = state == OP_APPLYING && timer_expired;

  // ----------------------------------------------------------------------
  // Registers written by the host
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_reg <= `CMD_RESET;
    end else if (doorbell) begin
      cmd_reg <= cmd_result;
    end else if (wr_cmd) begin
      cmd_reg <= pwdata[15:0];
    end
  end

  // Parameter pool; load index at +0, apply fields at +0, +4, +8
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      param0 <= 16'h0000;
      param1 <= 16'h0000;
      param2 <= 32'h00000000;
    end else if (wr) begin
      if (hit_p0) begin
        param0 <= pwdata[15:0];
      end
      if (hit_p1) begin
        param1 <= pwdata[15:0];
      end
      if (hit_p2) begin
        param2 <= pwdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Background operation
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= OP_IDLE;
      op_status <= `RES_ENOERR;
      apply_id <= 16'h0000;
    end else begin
      case (state)
        OP_IDLE: begin
          if (start_load) begin
            state <= OP_LOADING;
          end else if (start_apply) begin
            state <= OP_APPLYING;
            apply_id <= param1;
          end
        end
        OP_LOADING: begin
          if (nvm_rsp.done) begin
            if (!nvm_rsp.found) begin
              state <= OP_IDLE;
              op_status <= `RES_ENOENT;
            end else if (!nvm_rsp.ok) begin
              state <= OP_IDLE;
              op_status <= `RES_EIO;
            end else begin
              state <= OP_APPLYING;
              apply_id <= nvm_rsp.patch_id;
            end
          end
        end
        OP_APPLYING: begin
          if (timer_expired) begin
            state <= OP_IDLE;
            op_status <= `RES_ENOERR;
          end
        end
        default: begin
          state <= OP_IDLE;
        end
      endcase
    end
  end

  // Request to the NVM reader stays up until it reports done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nvm_req <= '0;
    end else if (start_load) begin
      nvm_req.valid <= 1'b1;
      nvm_req.index <= param0;
    end else if (nvm_rsp.done) begin
      nvm_req.valid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Patch RAM bookkeeping
  // ----------------------------------------------------------------------
  // Set wins over clear if a load lands as a reservation completes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      region_used <= 1'b0;
      reserved_total <= 16'h0000;
      reserve_start <= 16'h0000;
    end else begin
      if (load_ok) begin
        region_used <= 1'b1;
      end else if (reserve_ok) begin
        region_used <= 1'b0;
      end
      if (reserve_ok) begin
        reserved_total <= reserved_total + param1;
        reserve_start <= param0;
      end
    end
  end

  // Slots wrap after the last one; ids are stored as given
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_ptr <= '0;
      slot_count <= '0;
    end else if (slot_we) begin
      slot_ptr <= slot_ptr + SW'(1);
      if (slot_count != (SW+1)'(SLOTS)) begin
        slot_count <= slot_count + (SW+1)'(1);
      end
    end
  end

  patch_op_timer #(
    .WIDTH(8)
  ) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .start(start_timer),
    .cycles(APPLY_N),
    .expired(timer_expired)
  );

  patch_slot_mem #(
    .DEPTH(SLOTS),
    .WIDTH(16)
  ) u_slots (
    .pclk(pclk),
    .we(slot_we),
    .waddr(slot_ptr),
    .wdata(apply_id),
    .raddr(slot_raddr),
    .rdata(slot_rdata)
  );

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  wire [31:0] state_word = {op_status, 8'h00, 4'(slot_count),
    2'b00, region_used, op_busy};
  wire [31:0] rd_word = hit_cmd ? {16'h0000, cmd_reg} :
    hit_p0 ? {16'h0000, param0} :
    hit_p1 ? {16'h0000, param1} :
    hit_p2 ? param2 :
    hit_state ? state_word :
    hit_ram ? {reserve_start, free_bytes} : 32'h00000000;

  // Registered during the setup phase, so the access phase needs no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else begin
      prdata_q <= rd_word;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  localparam int APPLY_MAX = 8;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_LOAD_START: assert property (
    start_load |=> nvm_req.valid && nvm_req.index == $past(param0) && state == OP_LOADING)
    else $error("load accepted without NVM request");

  AST_LOAD_ACCEPT: assert property (
    is_load && !op_busy && nvm_present && !region_used |=> cmd_reg == `RES_ENOERR)
    else $error("accepted load did not answer ENOERR");

  AST_NODEV: assert property (
    is_load && !op_busy && !nvm_present |=> cmd_reg == `RES_ENODEV && state == OP_IDLE)
    else $error("missing NVM not reported as ENODEV");

  AST_RANGE: assert property (
    is_load && !op_busy && nvm_present && region_used |=> cmd_reg == `RES_ERANGE)
    else $error("occupied region not reported as ERANGE");

  AST_BUSY_REJECT: assert property (
    (is_load || is_apply) && op_busy |=> cmd_reg == `RES_EBUSY && $stable(nvm_req.index))
    else $error("request while busy not rejected");

  AST_NOENT: assert property (
    load_done && !nvm_rsp.found |=> op_status == `RES_ENOENT && state == OP_IDLE)
    else $error("missing patch not reported as ENOENT");

  AST_EIO: assert property (
    load_done && nvm_rsp.found && !nvm_rsp.ok |=> op_status == `RES_EIO && !nvm_req.valid)
    else $error("failed transfer not reported as EIO");

  AST_STATUS_BUSY: assert property (
    is_status && op_busy |=> cmd_reg == `RES_EBUSY)
    else $error("status query while busy did not answer EBUSY");

  AST_INVAL: assert property (
    is_apply && !op_busy && addr_bad |=> cmd_reg == `RES_EINVAL && state == OP_IDLE)
    else $error("bad loader address not reported as EINVAL");

  AST_BADF: assert property (
    is_apply && !op_busy && !addr_bad && fw_bad |=> cmd_reg == `RES_EBADF)
    else $error("firmware mismatch not reported as EBADF");

  AST_SLOT_WRITE: assert property (
    start_timer |-> ##[1:APPLY_MAX] slot_we)
    else $error("apply did not publish its identifier in time");

  AST_RESERVE: assert property (
    is_reserve |=> cmd_reg == ($past(no_room) ? `RES_EBUSY : `RES_ENOERR))
    else $error("reserve answered with wrong status");

  AST_DOORBELL: assert property (
    doorbell |=> !doorbell)
    else $error("doorbell not cleared on completion");

  COV_LOAD_OK: cover property (start_load ##[1:300] load_ok ##[1:APPLY_MAX] slot_we);
  COV_APPLY: cover property (start_apply ##[1:APPLY_MAX] slot_we);
  COV_RESERVE_FULL: cover property (is_reserve && no_room);
  COV_NOENT: cover property (load_done && !nvm_rsp.found);
endmodule : patch_loader_command_handler

// File: verif/nvm_responder_model.sv
// Behavioural non-volatile memory responder for the patch loader
`timescale 1ns/10ps
module nvm_responder_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] delay,
  input wire logic found_cfg,
  input wire logic ok_cfg,
  input wire logic [15:0] id_base,
  input wire patch_loader_pkg::nvm_req_type nvm_req,
  output patch_loader_pkg::nvm_rsp_type nvm_rsp
);
  import patch_loader_pkg::*;
  logic [7:0] count;
  logic pending;
  logic served;
  // ----------------------------------------------------------------------
  // Response engine
  // ----------------------------------------------------------------------
  // Served blocks a second answer while valid is still high after done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 8'h00;
      pending <= 1'b0;
      served <= 1'b0;
      nvm_rsp <= '0;
    end else begin
      nvm_rsp.done <= 1'b0;
      // Qualifiers churn outside done so stale values are never trusted
      nvm_rsp.found <= ~nvm_rsp.found;
      nvm_rsp.ok <= ~nvm_rsp.ok;
      nvm_rsp.patch_id <= ~nvm_rsp.patch_id;
      if (!nvm_req.valid) begin
        served <= 1'b0;
      end
      if (nvm_req.valid && !pending && !served) begin
        pending <= 1'b1;
        count <= delay;
      end else if (pending && count != 8'h00) begin
        count <= count - 8'h01;
      end else if (pending) begin
        pending <= 1'b0;
        served <= 1'b1;
        nvm_rsp.done <= 1'b1;
        nvm_rsp.found <= found_cfg;
        nvm_rsp.ok <= ok_cfg;
        nvm_rsp.patch_id <= id_base ^ nvm_req.index;
      end
    end
  end
endmodule : nvm_responder_model

// File: verif/test_patch_loader_command_handler.sv
// Self-checking testbench for the patch loader command handler
`timescale 1ns/10ps
`include "patch_loader_defines.svh"
module test_patch_loader_command_handler;
  import patch_loader_pkg::*;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic nvm_present;
  nvm_req_type nvm_req;
  nvm_rsp_type nvm_rsp;
  logic [7:0] delay;
  logic found_cfg;
  logic ok_cfg;
  logic [15:0] id_base;
  logic [31:0] q;
  logic [15:0] res;
  logic err;
  int fails;
  int n_checks;
  `define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin fails++; \
    $display("wrong value %s expected %h seen %h", nm, ex, got); end end

  patch_loader_command_handler DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .nvm_present(nvm_present), .nvm_req(nvm_req),
    .nvm_rsp(nvm_rsp));
  nvm_responder_model far_side (.pclk(pclk), .presetn(presetn), .delay(delay),
    .found_cfg(found_cfg), .ok_cfg(ok_cfg), .id_base(id_base), .nvm_req(nvm_req),
    .nvm_rsp(nvm_rsp));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // ----------------------------------------------------------------------
  // Bus and command tasks
  // ----------------------------------------------------------------------
  task automatic end_of_test;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  // Request stands until pready is seen high at a rising edge; data taken at that edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    logic rdy;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    rdy = 1'b0;
    for (i = 0; i < 16 && !rdy; i++) begin
      @(posedge pclk);
      rdy = (pready === 1'b1);
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (!rdy) begin
      fails++;
      end_of_test();
    end
  endtask : apb

  task automatic issue(input logic [15:0] code);
    int i;
    apb(1'b1, `OFF_CMD, {16'h0000, code});
    for (i = 0; i < 32; i++) begin
      apb(1'b0, `OFF_CMD, 32'h00000000);
      if (q[15] === 1'b0) break;
    end
    if (i == 32) begin
      fails++;
      end_of_test();
    end
    res = q[15:0];
  endtask : issue

  task automatic status_wait(input logic [15:0] ex);
    int i;
    for (i = 0; i < 200; i++) begin
      issue(`CMD_STATUS);
      if (res !== `RES_EBUSY) break;
    end
    if (i == 200) begin
      fails++;
      end_of_test();
    end
    `CHK("final status", ex, res)
  endtask : status_wait
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_misc;
    apb(1'b0, `OFF_STATE, 32'h00000000);
    `CHK("state at reset", 32'h00000000, q)
    apb(1'b0, `OFF_RAM, 32'h00000000);
    `CHK("free bytes at reset", `RAM_BYTES_DEF, q[15:0])
    apb(1'b0, 8'h40, 32'h00000000);
    `CHK("unmapped error", 1'b1, err)
    apb(1'b1, `OFF_STATE, 32'hFFFFFFFF);
    apb(1'b0, `OFF_STATE, 32'h00000000);
    `CHK("state read only", 32'h00000000, q)
    issue(16'h8703);
    `CHK("unknown code", `RES_ENOSYS, res)
    $display("test misc done");
  endtask : t_misc

  task automatic t_no_nvm;
    nvm_present <= 1'b0;
    apb(1'b1, `OFF_PARAM0, 32'h00000002);
    issue(`CMD_LOAD);
    `CHK("load without nvm", `RES_ENODEV, res)
    `CHK("no nvm request", 1'b0, nvm_req.valid)
    nvm_present <= 1'b1;
    $display("test no nvm done");
  endtask : t_no_nvm

  task automatic t_load;
    apb(1'b1, `OFF_PARAM0, 32'h00000003);
    issue(`CMD_LOAD);
    `CHK("load accept", `RES_ENOERR, res)
    `CHK("doorbell cleared", 1'b0, q[15])
    `CHK("nvm valid", 1'b1, nvm_req.valid)
    `CHK("nvm index", 16'h0003, nvm_req.index)
    apb(1'b0, `OFF_STATE, 32'h00000000);
    `CHK("busy flag", 1'b1, q[0])
    issue(`CMD_APPLY);
    `CHK("apply while busy", `RES_EBUSY, res)
    issue(`CMD_LOAD);
    `CHK("load while busy", `RES_EBUSY, res)
    issue(`CMD_STATUS);
    `CHK("status running", `RES_EBUSY, res)
    status_wait(`RES_ENOERR);
    apb(1'b0, `OFF_SLOT0, 32'h00000000);
    `CHK("loaded slot", id_base ^ 16'h0003, q[15:0])
    apb(1'b0, `OFF_STATE, 32'h00000000);
    `CHK("state after load", 32'h00000012, q)
    $display("test load done");
  endtask : t_load

  task automatic t_reserve;
    issue(`CMD_LOAD);
    `CHK("load into used area", `RES_ERANGE, res)
    apb(1'b1, `OFF_PARAM0, {16'h0000, `RAM_BASE_DEF});
    apb(1'b1, `OFF_PARAM1, {16'h0000, `RAM_BYTES_DEF + 16'h0001});
    issue(`CMD_RESERVE);
    `CHK("reserve too large", `RES_EBUSY, res)
    apb(1'b1, `OFF_PARAM1, 32'h00000100);
    issue(`CMD_RESERVE);
    `CHK("reserve ok", `RES_ENOERR, res)
    apb(1'b0, `OFF_RAM, 32'h00000000);
    `CHK("free after reserve", `RAM_BYTES_DEF - 16'h0100, q[15:0])
    `CHK("reserve start", `RAM_BASE_DEF, q[31:16])
    $display("test reserve done");
  endtask : t_reserve

  task automatic t_load_fail;
    found_cfg <= 1'b0;
    issue(`CMD_LOAD);
    `CHK("missing accept", `RES_ENOERR, res)
    status_wait(`RES_ENOENT);
    found_cfg <= 1'b1;
    ok_cfg <= 1'b0;
    issue(`CMD_LOAD);
    `CHK("bad transfer accept", `RES_ENOERR, res)
    status_wait(`RES_EIO);
    ok_cfg <= 1'b1;
    $display("test load fail done");
  endtask : t_load_fail

  task automatic t_apply;
    int k;
    apb(1'b1, `OFF_PARAM0, {16'h0000, `RAM_BASE_DEF - 16'h0001});
    apb(1'b1, `OFF_PARAM1, 32'h000000A5);
    apb(1'b1, `OFF_PARAM2, `ROM_FW_ID_DEF);
    issue(`CMD_APPLY);
    `CHK("loader below range", `RES_EINVAL, res)
    apb(1'b1, `OFF_PARAM0, {16'h0000, `RAM_BASE_DEF + `RAM_BYTES_DEF});
    issue(`CMD_APPLY);
    `CHK("loader above range", `RES_EINVAL, res)
    apb(1'b1, `OFF_PARAM0, {16'h0000, `RAM_BASE_DEF + `RAM_BYTES_DEF - 16'h0001});
    apb(1'b1, `OFF_PARAM2, `ROM_FW_ID_DEF ^ 32'h00000001);
    issue(`CMD_APPLY);
    `CHK("wrong firmware", `RES_EBADF, res)
    apb(1'b1, `OFF_PARAM2, `ROM_FW_ID_DEF);
    // The same identifier twice must land in two slots
    for (k = 1; k < 3; k++) begin
      issue(`CMD_APPLY);
      `CHK("apply accept", `RES_ENOERR, res)
      status_wait(`RES_ENOERR);
      apb(1'b0, `OFF_SLOT0 + 8'(4 * k), 32'h00000000);
      `CHK("applied slot", 16'h00A5, q[15:0])
    end
    apb(1'b0, `OFF_STATE, 32'h00000000);
    `CHK("state after apply", 32'h00000030, q)
    $display("test apply done");
  endtask : t_apply

  initial begin
    fails = 0;
    n_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    nvm_present = 1'b1;
    delay = 8'h28;
    found_cfg = 1'b1;
    ok_cfg = 1'b1;
    id_base = 16'h3C00;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_misc();
    t_no_nvm();
    t_load();
    t_reserve();
    t_load_fail();
    t_apply();
    end_of_test();
  end
endmodule : test_patch_loader_command_handler
